// *** amux_pin_select_pkg.sv ***
// Functional notes
// - Port 2 select bit n set connects port 2 pin n to the shared mux.
// - Port 3 select bit n set connects port 3 pin n to the shared mux.
// - Port 2 select at page 0x0 address 0x9c, port 3 at 0xa4, fully read/write.
// - Reset clears both select registers so every pin switch is open.
package amux_pin_select_pkg;
  localparam logic [7:0] SFR_PAGE = 8'h00;
  localparam logic [7:0] PORT2_SELECT_ADDR = 8'h9c;
  localparam logic [7:0] PORT3_SELECT_ADDR = 8'ha4;
  localparam logic [7:0] SELECT_RESET = 8'h00;
  localparam int PIN0_SWITCH_BIT = 0;
  localparam int PIN7_SWITCH_BIT = 7;
endpackage

// *** pin_select_reg.sv ***
module pin_select_reg (
  input wire logic clk, // Core clock.
  input wire logic rst_b, // Synchronous reset, active low.
  input wire logic write_hit, // Write strobe decoded for this register.
  input wire logic [7:0] write_data, // Byte to store.
  output logic [7:0] value // Stored switch bits.
);
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      value <= amux_pin_select_pkg::SELECT_RESET;
    end else if (write_hit) begin
      value <= write_data;
    end
  end

  chk_reset_clears: assert property (@(posedge clk)
    !rst_b |=> value == amux_pin_select_pkg::SELECT_RESET)
    else $error("select register not cleared by reset");

  chk_write_stores: assert property (@(posedge clk) disable iff (!rst_b)
    write_hit |=> value == $past(write_data))
    else $error("select register did not store written byte");

  chk_hold_idle: assert property (@(posedge clk) disable iff (!rst_b)
    !write_hit && $past(rst_b) |=> $stable(value))
    else $error("select register changed without a write");
endmodule

// *** analog_input_pin_select_p2_p3.sv ***
module analog_input_pin_select_p2_p3 (
  input wire logic clk, // Core clock.
  input wire logic rst_b, // Synchronous system reset, active low.
  input wire logic [7:0] sfr_page, // Current special-function page.
  input wire logic [7:0] sfr_addr, // Special-function address.
  input wire logic sfr_wr, // Write strobe, one cycle.
  input wire logic sfr_rd, // Read strobe, one cycle.
  input wire logic [7:0] sfr_wdata, // Write data.
  output logic [7:0] sfr_rdata, // Read data, registered.
  output logic sfr_rvalid, // Read data valid, one-cycle pulse.
  output logic [7:0] port2_analog_pin_select, // Port 2 switch closes, bit n is pin n.
  output logic [7:0] port3_analog_pin_select // Port 3 switch closes, bit n is pin n.
);
  logic page_hit;
  logic p2_hit;
  logic p3_hit;
  logic [7:0] p2_value;
  logic [7:0] p3_value;
  logic [7:0] next_rdata;

  // Both registers decode the same way, so the page and address match is shared here.
  function automatic logic reg_hit(input logic [7:0] page, input logic [7:0] addr,
      input logic [7:0] target);
    return page == amux_pin_select_pkg::SFR_PAGE && addr == target;
  endfunction

  assign page_hit = sfr_page == amux_pin_select_pkg::SFR_PAGE;
  assign p2_hit = reg_hit(sfr_page, sfr_addr, amux_pin_select_pkg::PORT2_SELECT_ADDR);
  assign p3_hit = reg_hit(sfr_page, sfr_addr, amux_pin_select_pkg::PORT3_SELECT_ADDR);

  pin_select_reg port2_reg (
    .clk(clk),
    .rst_b(rst_b),
    .write_hit(sfr_wr && p2_hit),
    .write_data(sfr_wdata),
    .value(p2_value)
  );

  pin_select_reg port3_reg (
    .clk(clk),
    .rst_b(rst_b),
    .write_hit(sfr_wr && p3_hit),
    .write_data(sfr_wdata),
    .value(p3_value)
  );

  // Switch drives are copies of the stored bits, so they trail the register by a cycle.
  // Keeping outputs on flops avoids glitches on the analog switch gates.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      port2_analog_pin_select <= amux_pin_select_pkg::SELECT_RESET;
      port3_analog_pin_select <= amux_pin_select_pkg::SELECT_RESET;
    end else begin
      port2_analog_pin_select <= p2_value;
      port3_analog_pin_select <= p3_value;
    end
  end

  // Unmapped addresses read as zero so other peripherals can share the bus by OR.
  always_comb begin
    next_rdata = 8'h00;
    if (p2_hit) begin
      next_rdata = p2_value;
    end else if (p3_hit) begin
      next_rdata = p3_value;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sfr_rdata <= 8'h00;
      sfr_rvalid <= 1'b0;
    end else begin
      sfr_rdata <= sfr_rd ? next_rdata : 8'h00;
      sfr_rvalid <= sfr_rd;
    end
  end

  chk_p2_follows: assert property (@(posedge clk) disable iff (!rst_b)
    sfr_wr && p2_hit ##1 rst_b |=> port2_analog_pin_select == $past(sfr_wdata, 2))
    else $error("port 2 switches do not follow written byte");

  chk_p3_follows: assert property (@(posedge clk) disable iff (!rst_b)
    sfr_wr && p3_hit ##1 rst_b |=> port3_analog_pin_select == $past(sfr_wdata, 2))
    else $error("port 3 switches do not follow written byte");

  chk_reset_open: assert property (@(posedge clk)
    !rst_b ##1 !rst_b |-> port2_analog_pin_select == 8'h00 && port3_analog_pin_select == 8'h00)
    else $error("pin switches not open in reset");

  chk_p2_readback: assert property (@(posedge clk) disable iff (!rst_b)
    sfr_rd && p2_hit |=> sfr_rvalid && sfr_rdata == $past(p2_value))
    else $error("port 2 readback wrong");

  chk_p3_readback: assert property (@(posedge clk) disable iff (!rst_b)
    sfr_rd && p3_hit |=> sfr_rvalid && sfr_rdata == $past(p3_value))
    else $error("port 3 readback wrong");

  chk_unmapped_zero: assert property (@(posedge clk) disable iff (!rst_b)
    sfr_rd && !p2_hit && !p3_hit |=> sfr_rdata == 8'h00)
    else $error("unmapped read not zero");

  chk_other_page: assert property (@(posedge clk) disable iff (!rst_b)
    sfr_wr && !page_hit ##1 1'b1 |=> $stable(port2_analog_pin_select)
      && $stable(port3_analog_pin_select))
    else $error("write on another page changed switches");

  chk_no_read_quiet: assert property (@(posedge clk) disable iff (!rst_b)
    !sfr_rd |=> !sfr_rvalid && sfr_rdata == 8'h00)
    else $error("read data driven without read");

  // Outside reset, the switch drives must be the stored bits of one cycle earlier.
  // A mismatch here would mean a pin closes without software having asked for it.
  chk_p2_tracks_reg: assert property (@(posedge clk) disable iff (!rst_b)
    $past(rst_b) |-> port2_analog_pin_select == $past(p2_value))
    else $error("port 2 switches differ from stored bits");

  chk_p3_tracks_reg: assert property (@(posedge clk) disable iff (!rst_b)
    $past(rst_b) |-> port3_analog_pin_select == $past(p3_value))
    else $error("port 3 switches differ from stored bits");

  // The end bits are checked one by one, so a swapped bit order cannot hide in a byte compare.
  chk_p2_pin0_bit: assert property (@(posedge clk) disable iff (!rst_b)
    sfr_wr && p2_hit ##1 rst_b |=>
      port2_analog_pin_select[amux_pin_select_pkg::PIN0_SWITCH_BIT]
        == $past(sfr_wdata[amux_pin_select_pkg::PIN0_SWITCH_BIT], 2))
    else $error("port 2 pin 0 switch wrong");

  chk_p2_pin7_bit: assert property (@(posedge clk) disable iff (!rst_b)
    sfr_wr && p2_hit ##1 rst_b |=>
      port2_analog_pin_select[amux_pin_select_pkg::PIN7_SWITCH_BIT]
        == $past(sfr_wdata[amux_pin_select_pkg::PIN7_SWITCH_BIT], 2))
    else $error("port 2 pin 7 switch wrong");

  chk_p3_pin0_bit: assert property (@(posedge clk) disable iff (!rst_b)
    sfr_wr && p3_hit ##1 rst_b |=>
      port3_analog_pin_select[amux_pin_select_pkg::PIN0_SWITCH_BIT]
        == $past(sfr_wdata[amux_pin_select_pkg::PIN0_SWITCH_BIT], 2))
    else $error("port 3 pin 0 switch wrong");

  chk_p3_pin7_bit: assert property (@(posedge clk) disable iff (!rst_b)
    sfr_wr && p3_hit ##1 rst_b |=>
      port3_analog_pin_select[amux_pin_select_pkg::PIN7_SWITCH_BIT]
        == $past(sfr_wdata[amux_pin_select_pkg::PIN7_SWITCH_BIT], 2))
    else $error("port 3 pin 7 switch wrong");

  // A write aimed at one register must never touch the other one.
  chk_p2_untouched: assert property (@(posedge clk) disable iff (!rst_b)
    !(sfr_wr && p2_hit) && $past(rst_b) |=> $stable(p2_value))
    else $error("port 2 register changed by another write");

  chk_p3_untouched: assert property (@(posedge clk) disable iff (!rst_b)
    !(sfr_wr && p3_hit) && $past(rst_b) |=> $stable(p3_value))
    else $error("port 3 register changed by another write");

  // Reset clears the stored bits at the first low edge.
  chk_reset_regs: assert property (@(posedge clk)
    !rst_b |=> p2_value == 8'h00 && p3_value == 8'h00)
    else $error("select registers not cleared by reset");

  // The first edge after release must still see every switch open.
  // This catches an output stage that kept its old value through reset.
  chk_release_open: assert property (@(posedge clk)
    rst_b && $past(!rst_b) |-> port2_analog_pin_select == 8'h00
      && port3_analog_pin_select == 8'h00 && !sfr_rvalid)
    else $error("pin switches not open after reset release");

  chk_reset_quiet: assert property (@(posedge clk)
    !rst_b |=> !sfr_rvalid && sfr_rdata == 8'h00)
    else $error("read port busy during reset");

  // Every read strobe is answered, mapped or not, so software never waits.
  chk_rvalid_pulse: assert property (@(posedge clk) disable iff (!rst_b)
    sfr_rd |=> sfr_rvalid)
    else $error("read not answered");

  // A read that meets a write in one cycle returns the byte held before it.
  chk_p2_read_old: assert property (@(posedge clk) disable iff (!rst_b)
    sfr_rd && sfr_wr && p2_hit |=> sfr_rdata == $past(p2_value) && p2_value == $past(sfr_wdata))
    else $error("port 2 read during write wrong");

  chk_p3_read_old: assert property (@(posedge clk) disable iff (!rst_b)
    sfr_rd && sfr_wr && p3_hit |=> sfr_rdata == $past(p3_value) && p3_value == $past(sfr_wdata))
    else $error("port 3 read during write wrong");

  // A read on another page must not leak either register onto the shared bus.
  chk_page_read_zero: assert property (@(posedge clk) disable iff (!rst_b)
    sfr_rd && !page_hit |=> sfr_rdata == 8'h00)
    else $error("read on another page not zero");

  // The switch stage only moves in the cycle after the register moved.
  chk_p2_out_quiet: assert property (@(posedge clk) disable iff (!rst_b)
    $past(rst_b) && $stable(p2_value) |=> $stable(port2_analog_pin_select))
    else $error("port 2 switches moved on their own");

  chk_p3_out_quiet: assert property (@(posedge clk) disable iff (!rst_b)
    $past(rst_b) && $stable(p3_value) |=> $stable(port3_analog_pin_select))
    else $error("port 3 switches moved on their own");
endmodule

// *** amux_model.sv ***
module amux_model (
  input wire logic [7:0] p2_sel, // Port 2 switch closes.
  input wire logic [7:0] p3_sel, // Port 3 switch closes.
  output logic [4:0] pins_on // Pins tied onto the shared mux.
);
  timeunit 1ns;
  timeprecision 1ns;
  // Each closed switch adds one pin to the shared mux node.
  always_comb pins_on = 5'($countones({p3_sel, p2_sel}));
endmodule

// *** tb.sv ***
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic sfr_wr = 1'b0;
  logic sfr_rd = 1'b0;
  logic sfr_rvalid;
  logic [7:0] sfr_page = 8'h00;
  logic [7:0] sfr_addr = 8'h00;
  logic [7:0] sfr_wdata = 8'h00;
  logic [7:0] sfr_rdata, p2, p3, d, a;
  logic [4:0] pins_on;
  logic [7:0] e2 = 8'h00;
  logic [7:0] e3 = 8'h00;
  int fail_count = 0;
  int n_compared = 0;
  int seed = 32'h13bec5f8;
  analog_input_pin_select_p2_p3 i_dut (.clk(clk), .rst_b(rst_b), .sfr_page(sfr_page),
    .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata), .sfr_rvalid(sfr_rvalid), .port2_analog_pin_select(p2),
    .port3_analog_pin_select(p3));
  amux_model i_mux (.p2_sel(p2), .p3_sel(p3), .pins_on(pins_on));
  function automatic logic [7:0] pin_count(input logic [7:0] x2, input logic [7:0] x3);
    logic [7:0] n;
    n = 8'h00;
    for (int b = 0; b < 8; b++) n = n + 8'(x2[b]) + 8'(x3[b]);
    return n;
  endfunction
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Ends after two edges, so the retimed switch outputs already show the write.
  task automatic wr(input logic [7:0] adr, input logic [7:0] v, input logic [7:0] pg);
    sfr_page = pg;
    sfr_addr = adr;
    sfr_wdata = v;
    sfr_wr = 1'b1;
    @(negedge clk);
    sfr_wr = 1'b0;
    sfr_page = 8'h00;
    @(negedge clk);
  endtask
  task automatic rd(input logic [7:0] adr, input logic [7:0] exp);
    sfr_addr = adr;
    sfr_rd = 1'b1;
    @(negedge clk);
    sfr_rd = 1'b0;
    check({7'h00, sfr_rvalid}, 8'h01);
    check(sfr_rdata, exp);
  endtask
  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial forever #5 clk = ~clk;
  initial begin
    repeat (6) @(negedge clk);
    rst_b = 1'b1;
    check(p2 | p3, amux_pin_select_pkg::SELECT_RESET);
    rd(amux_pin_select_pkg::PORT3_SELECT_ADDR, amux_pin_select_pkg::SELECT_RESET);
    for (int i = 0; i < 24; i++) begin
      a = i[0] ? amux_pin_select_pkg::PORT3_SELECT_ADDR : amux_pin_select_pkg::PORT2_SELECT_ADDR;
      d = (i < 2) ? 8'hff : 8'($random(seed));
      wr(a, d, amux_pin_select_pkg::SFR_PAGE);
      check(i[0] ? p3 : p2, d);
      if (i[0]) e3 = d;
      else e2 = d;
      check({3'h0, pins_on}, pin_count(e2, e3));
      rd(a, d);
      wr(a, ~d, 8'h01);
      check(i[0] ? p3 : p2, d);
    end
    rd(8'h9b, 8'h00);
    // A write and a read in one cycle must return the byte held before the write.
    sfr_addr = amux_pin_select_pkg::PORT2_SELECT_ADDR;
    sfr_wdata = 8'h5a;
    sfr_wr = 1'b1;
    sfr_rd = 1'b1;
    @(negedge clk);
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    check(sfr_rdata, e2);
    @(negedge clk);
    check(p2, 8'h5a);
    // A reset in mid-run must open every switch again.
    rst_b = 1'b0;
    repeat (2) @(negedge clk);
    rst_b = 1'b1;
    check(p2 | p3, amux_pin_select_pkg::SELECT_RESET);
    rd(amux_pin_select_pkg::PORT2_SELECT_ADDR, amux_pin_select_pkg::SELECT_RESET);
    rd(amux_pin_select_pkg::PORT3_SELECT_ADDR, amux_pin_select_pkg::SELECT_RESET);
    wr(amux_pin_select_pkg::PORT3_SELECT_ADDR, 8'h81, 8'h00);
    check({3'h0, pins_on}, pin_count(8'h00, 8'h81));
    // An internal channel is about to be chosen, so every pin select is cleared first.
    wr(amux_pin_select_pkg::PORT2_SELECT_ADDR, 8'h00, 8'h00);
    wr(amux_pin_select_pkg::PORT3_SELECT_ADDR, 8'h00, 8'h00);
    check({3'h0, pins_on}, 8'h00);
    close_out;
  end
endmodule
